// *** verilog/sol_regs.sv ***
// Output stage, feedback, bleed and lock-detect control register bank
// Functional notes
// - Source bit picks automatic or manual coefficients
// - Feedback bit picks N counter source, resets 1
// - Divider codes 1..64, 111 reserved, double-buffer option
// - Output enable resets on; doubler bit switches path
// - Power codes give -4,-1,2,5 dBm, reset 11
// - Window code gives 5,6,8,12 ns, reset 11
// - Precision bit: fractional 5 ns, integer 2.4 ns
// - Gated bleed follows digital lock detect
// - Bleed enable turns negative bleed on, reset 0
// - Regulator bit high disables oscillator LDO
`timescale 1ns/100ps
module sol_regs
    import sol_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic buffer_load_in,
    input wire logic lock_detect_in,
    input wire logic [15:0] auto_coef_in,
    input wire logic [15:0] manual_coef_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic reg_hit_out,
    output logic [15:0] coef_out,
    output sol_ctrl_t ctrl_out,
    output logic [2:0] div_code_out,
    output logic [6:0] div_ratio_out,
    output logic div_reserved_out
);

    logic [4:0][7:0] regs_q;
    logic [2:0] idx;
    logic wr_hit;
    sol_ctrl_t ctrl_d;

    function automatic logic is_mapped(input logic [7:0] addr);
        return (addr >= SOL_TRK_OFF) && (addr <= SOL_LOCK_OFF);
    endfunction

    function automatic logic [7:0] window_100ps(input logic [1:0] code);
        logic [7:0] t;
        t = SOL_WIN_CODE0_100PS;
        unique case (code)
            2'h0: t = SOL_WIN_CODE0_100PS;
            2'h1: t = SOL_WIN_CODE1_100PS;
            2'h2: t = SOL_WIN_CODE2_100PS;
            2'h3: t = SOL_WIN_CODE3_100PS;
        endcase
        return t;
    endfunction

    function automatic logic signed [3:0] power_dbm(input logic [1:0] code);
        logic signed [3:0] p;
        p = SOL_PWR_CODE0_DBM;
        unique case (code)
            2'h0: p = SOL_PWR_CODE0_DBM;
            2'h1: p = SOL_PWR_CODE1_DBM;
            2'h2: p = SOL_PWR_CODE2_DBM;
            2'h3: p = SOL_PWR_CODE3_DBM;
        endcase
        return p;
    endfunction

    assign idx = 3'(reg_addr_in - SOL_TRK_OFF);
    assign wr_hit = reg_wr_in && is_mapped(reg_addr_in);

    // Each register keeps only its writable bits; the rest stay at zero
    genvar gi;
    generate
        for (gi = 0; gi < SOL_NUM_REGS; gi++) begin : g_reg
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    regs_q[gi] <= SOL_RESET_VALS[gi];
                end else if (wr_hit && (idx == 3'(gi))) begin
                    regs_q[gi] <= (reg_wdata_in & SOL_WRITE_MASKS[gi]) |
                        (regs_q[gi] & ~SOL_WRITE_MASKS[gi]);
                end
            end
        end
    endgenerate

    // Read data lands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
            reg_hit_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            reg_hit_out <= (reg_rd_in || reg_wr_in) && is_mapped(reg_addr_in);
            if (reg_rd_in) begin
                reg_rdata_out <= is_mapped(reg_addr_in) ?
                    (regs_q[idx] & SOL_WRITE_MASKS[idx]) : 8'h00;
            end
        end
    end

    // Field decode to the analog and PLL controls
    always_comb begin
        ctrl_d.manual_coef_sel = regs_q[0][SOL_TRK_MANUAL_BIT];
        ctrl_d.n_counter_source = regs_q[1][SOL_N_SRC_BIT];
        ctrl_d.output_enable = regs_q[2][SOL_OUT_EN_BIT];
        ctrl_d.doubler_path_on = regs_q[2][SOL_DOUBLER_BIT];
        ctrl_d.output_power_level = regs_q[2][SOL_PWR_LSB +: 2];
        ctrl_d.output_power_dbm =
            power_dbm(regs_q[2][SOL_PWR_LSB +: 2]);
        ctrl_d.bleed_level = regs_q[3];
        ctrl_d.bleed_enable = regs_q[4][SOL_BLEED_EN_BIT];
        // Gating trusts software to have the lock detector running first
        ctrl_d.bleed_active = regs_q[4][SOL_BLEED_EN_BIT] &&
            (!regs_q[4][SOL_BLEED_GATE_BIT] || lock_detect_in);
        ctrl_d.lock_window_100ps =
            window_100ps(regs_q[4][SOL_LD_WIN_LSB +: 2]);
        ctrl_d.lock_precision = regs_q[4][SOL_LD_PREC_BIT];
        ctrl_d.lock_precision_100ps = regs_q[4][SOL_LD_PREC_BIT] ?
            SOL_PREC_INT_100PS : SOL_PREC_FRAC_100PS;
        ctrl_d.osc_ldo_enable = !regs_q[4][SOL_LDO_OFF_BIT];
    end

    // Controls are registered so every output leaves a flip-flop;
    // this costs one cycle of latency after a write
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_out <= '0;
        end else begin
            ctrl_out <= ctrl_d;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            coef_out <= 16'h0000;
        end else begin
            coef_out <= regs_q[0][SOL_TRK_MANUAL_BIT] ?
                manual_coef_in : auto_coef_in;
        end
    end

    sol_div_stage u_div (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .div_sel_in(regs_q[1][SOL_DIV_LSB +: 3]),
        .double_buffer_in(regs_q[2][SOL_DBUF_BIT]),
        .load_in(buffer_load_in),
        .div_code_out(div_code_out),
        .div_ratio_out(div_ratio_out),
        .reserved_code_out(div_reserved_out)
    );

endmodule // sol_regs

// *** verilog/sol_pkg.sv ***
// Constants, register map and control carrier for the output/lock-detect bank
package sol_pkg;

    localparam int SOL_NUM_REGS = 5;

    // Byte offsets on the serial register port
    localparam logic [7:0] SOL_TRK_OFF = 8'h23;
    localparam logic [7:0] SOL_FB_OFF = 8'h24;
    localparam logic [7:0] SOL_OUT_OFF = 8'h25;
    localparam logic [7:0] SOL_BLEED_OFF = 8'h26;
    localparam logic [7:0] SOL_LOCK_OFF = 8'h27;
    // Tracking-filter coefficient registers that the manual mode uses
    localparam logic [7:0] SOL_COEF_LO_OFF = 8'h70;
    localparam logic [7:0] SOL_COEF_HI_OFF = 8'h71;

    // Index 0 is offset 0x23, index 4 is offset 0x27
    localparam logic [4:0][7:0] SOL_RESET_VALS =
        {8'hC5, 8'h32, 8'h07, 8'h80, 8'h00};
    // Writable bits; zeros are read-only reserved and read as zero
    localparam logic [4:0][7:0] SOL_WRITE_MASKS =
        {8'hFF, 8'hFF, 8'hBF, 8'hF0, 8'h32};

    // tracking_filter_control
    localparam int SOL_TRK_MANUAL_BIT = 1;
    // feedback_and_divider
    localparam int SOL_N_SRC_BIT = 7;
    localparam int SOL_DIV_LSB = 4;
    localparam logic [2:0] SOL_DIV_RESERVED = 3'h7;
    // output_stage_control
    localparam int SOL_DBUF_BIT = 5;
    localparam int SOL_DOUBLER_BIT = 3;
    localparam int SOL_OUT_EN_BIT = 2;
    localparam int SOL_PWR_LSB = 0;
    // lock_detect_and_bleed
    localparam int SOL_LD_WIN_LSB = 6;
    localparam int SOL_LD_PREC_BIT = 5;
    localparam int SOL_BLEED_GATE_BIT = 4;
    localparam int SOL_BLEED_EN_BIT = 3;
    localparam int SOL_LDO_OFF_BIT = 2;

    // Lock window delays in units of 100 ps
    localparam logic [7:0] SOL_WIN_CODE0_100PS = 8'h32;
    localparam logic [7:0] SOL_WIN_CODE1_100PS = 8'h3C;
    localparam logic [7:0] SOL_WIN_CODE2_100PS = 8'h50;
    localparam logic [7:0] SOL_WIN_CODE3_100PS = 8'h78;
    localparam logic [7:0] SOL_PREC_FRAC_100PS = 8'h32;
    localparam logic [7:0] SOL_PREC_INT_100PS = 8'h18;

    // Output power levels in dBm, two's complement
    localparam logic signed [3:0] SOL_PWR_CODE0_DBM = -4'sd4;
    localparam logic signed [3:0] SOL_PWR_CODE1_DBM = -4'sd1;
    localparam logic signed [3:0] SOL_PWR_CODE2_DBM = 4'sd2;
    localparam logic signed [3:0] SOL_PWR_CODE3_DBM = 4'sd5;

    typedef struct packed {
        logic manual_coef_sel;
        logic n_counter_source;
        logic output_enable;
        logic doubler_path_on;
        logic [1:0] output_power_level;
        logic signed [3:0] output_power_dbm;
        logic [7:0] bleed_level;
        logic bleed_enable;
        logic bleed_active;
        logic [7:0] lock_window_100ps;
        logic [7:0] lock_precision_100ps;
        logic lock_precision;
        logic osc_ldo_enable;
    } sol_ctrl_t;

endpackage

// *** verilog/sol_div_stage.sv ***
// Output divider stage: optional double buffering and ratio decode
`timescale 1ns/100ps
module sol_div_stage
    import sol_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [2:0] div_sel_in,
    input wire logic double_buffer_in,
    input wire logic load_in,
    output logic [2:0] div_code_out,
    output logic [6:0] div_ratio_out,
    output logic reserved_code_out
);

    logic [2:0] active_d;
    logic take;

    // A reserved code never reaches the divider; the last legal ratio holds
    assign take = (!double_buffer_in || load_in) &&
                  (div_sel_in != SOL_DIV_RESERVED);
    assign active_d = take ? div_sel_in : div_code_out;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            div_code_out <= 3'h0;
            div_ratio_out <= 7'h01;
        end else begin
            div_code_out <= active_d;
            div_ratio_out <= 7'h01 << active_d;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            reserved_code_out <= 1'b0;
        end else begin
            reserved_code_out <= (div_sel_in == SOL_DIV_RESERVED);
        end
    end

endmodule // sol_div_stage

// *** tb/sol_regs_monitor.sv ***
// Concurrent checks on the output and lock-detect register bank ports
`timescale 1ns/100ps
module sol_regs_monitor
    import sol_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_hit_out,
    input wire sol_ctrl_t ctrl_out,
    input wire logic [2:0] div_code_out,
    input wire logic [6:0] div_ratio_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence s_wr(logic [7:0] a);
        reg_wr_in && reg_addr_in == a;
    endsequence
    // Controls lag the write edge by two edges
    property p_fb;
        s_wr(SOL_FB_OFF) |-> ##2
            ctrl_out.n_counter_source == $past(reg_wdata_in[7], 2);
    endproperty
    a_fb: assert property (p_fb) else $error("feedback source");
    property p_out;
        s_wr(SOL_OUT_OFF) |-> ##2
            ctrl_out.output_enable == $past(reg_wdata_in[2], 2) &&
            ctrl_out.doubler_path_on == $past(reg_wdata_in[3], 2);
    endproperty
    a_out: assert property (p_out) else $error("output control");
    property p_ldo;
        s_wr(SOL_LOCK_OFF) |-> ##2
            ctrl_out.osc_ldo_enable != $past(reg_wdata_in[2], 2);
    endproperty
    a_ldo: assert property (p_ldo) else $error("regulator enable");
    property p_win;
        s_wr(SOL_LOCK_OFF) ##0 reg_wdata_in[7:6] == 2'h3 |-> ##2
            ctrl_out.lock_window_100ps == 8'h78;
    endproperty
    a_win: assert property (p_win) else $error("lock window");
    property p_prec;
        !$past(rst_in) |-> ctrl_out.lock_precision_100ps ==
            (ctrl_out.lock_precision ? 8'h18 : 8'h32);
    endproperty
    a_prec: assert property (p_prec) else $error("precision");
    property p_dbm;
        !$past(rst_in) |-> ctrl_out.output_power_dbm ==
            4'(3 * ctrl_out.output_power_level - 4);
    endproperty
    a_dbm: assert property (p_dbm) else $error("power level");
    property p_div;
        div_code_out != 3'h7 && div_ratio_out == 7'(1 << div_code_out);
    endproperty
    a_div: assert property (p_div) else $error("divider ratio");
    property p_unmap;
        reg_rd_in && (reg_addr_in < 8'h23 || reg_addr_in > 8'h27) |=>
            reg_rdata_out == 8'h00 && !reg_hit_out;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule // sol_regs_monitor
bind sol_regs sol_regs_monitor mon_u (.*);

// *** tb/sol_regs_test.sv ***
// Self-checking bench for the output and lock-detect register bank
`timescale 1ns/100ps
module sol_regs_test;
    import sol_pkg::*;
    logic clock_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic buffer_load_in = 0, lock_detect_in = 0;
    logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out;
    logic [15:0] auto_coef_in = 16'hA5C3, manual_coef_in = 16'h3C5A;
    logic [15:0] coef_out;
    logic reg_rvalid_out, reg_hit_out, div_reserved_out;
    logic [2:0] div_code_out;
    logic [6:0] div_ratio_out;
    sol_ctrl_t ctrl_out;
    int fail_count = 0, checks = 0, cyc = 0;
    sol_regs dut_u (.*);
    always #20 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Returns once the controls reflect the write
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clock_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1;
        @(negedge clock_in);
        reg_wr_in = 0;
        @(negedge clock_in);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clock_in);
        reg_addr_in = a;
        reg_rd_in = 1;
        @(negedge clock_in);
        reg_rd_in = 0;
        chk("rdata", 16'(reg_rdata_out), 16'(exp));
        chk("rvalid", 16'(reg_rvalid_out), 16'h0001);
        chk("hit", 16'(reg_hit_out), 16'(a >= 8'h23 && a <= 8'h27));
    endtask
    task automatic pulse_load();
        buffer_load_in = 1;
        @(negedge clock_in);
        buffer_load_in = 0;
        @(negedge clock_in);
    endtask
    task automatic t_reset();
        logic [7:0] rv [5] = '{8'h00, 8'h80, 8'h07, 8'h32, 8'hC5};
        for (int i = 0; i < 5; i++)
            rd(8'(8'h23 + i), rv[i]);
        chk("n_src", 16'(ctrl_out.n_counter_source), 16'h0001);
        chk("out_en", 16'(ctrl_out.output_enable), 16'h0001);
        chk("ldo_en", 16'(ctrl_out.osc_ldo_enable), 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_access();
        logic [7:0] m [5] = '{8'h32, 8'hF0, 8'hBF, 8'hFF, 8'hFF};
        for (int i = 0; i < 5; i++)
            wr(8'(8'h23 + i), 8'hFF);
        for (int i = 0; i < 5; i++)
            rd(8'(8'h23 + i), m[i]);
        wr(8'h28, 8'hFF);
        rd(8'h28, 8'h00);
        rd(8'h22, 8'h00);
        chk("coef", coef_out, manual_coef_in);
        chk("man_sel", 16'(ctrl_out.manual_coef_sel), 16'h0001);
        chk("bleed_en", 16'(ctrl_out.bleed_enable), 16'h0001);
        chk("prec", 16'(ctrl_out.lock_precision_100ps), 16'h0018);
        chk("div_rsv", 16'(div_reserved_out), 16'h0001);
        chk("ratio", 16'(div_ratio_out), 16'h0001);
        chk("gated", 16'(ctrl_out.bleed_active), 16'h0000);
        lock_detect_in = 1;
        repeat (2) @(negedge clock_in);
        chk("gated", 16'(ctrl_out.bleed_active), 16'h0001);
        for (int i = 0; i < 5; i++)
            wr(8'(8'h23 + i), 8'h00);
        chk("coef", coef_out, auto_coef_in);
        chk("ldo_en", 16'(ctrl_out.osc_ldo_enable), 16'h0001);
        chk("bleed", 16'(ctrl_out.bleed_active), 16'h0000);
        // Ungated bleed follows the enable bit alone
        wr(SOL_LOCK_OFF, 8'h08);
        chk("bleed", 16'(ctrl_out.bleed_active), 16'h0001);
        // Bleed level for a 2400 uA pump current and N of 32
        wr(SOL_BLEED_OFF, 8'((4 * 2400 * 100) / (32 * 375)));
        chk("bleed_lvl", 16'(ctrl_out.bleed_level), 16'h0050);
        $display("access test done");
    endtask
    task automatic t_modes();
        logic [7:0] w [4] = '{8'h32, 8'h3C, 8'h50, 8'h78};
        logic [15:0] e;
        for (int c = 0; c < 4; c++) begin
            wr(8'h25, 8'(c));
            e = {12'h000, 4'(3 * c - 4)};
            chk("dbm", {12'h000, ctrl_out.output_power_dbm}, e);
            wr(8'h27, 8'(c << 6));
            chk("win", 16'(ctrl_out.lock_window_100ps), 16'(w[c]));
        end
        for (int c = 0; c < 7; c++) begin
            wr(8'h24, 8'(c << 4));
            chk("ratio", 16'(div_ratio_out), 16'(1 << c));
        end
        // Buffered divider waits for the load event
        wr(8'h25, 8'h20);
        wr(8'h24, 8'h20);
        chk("ratio", 16'(div_ratio_out), 16'h0040);
        pulse_load();
        chk("ratio", 16'(div_ratio_out), 16'h0004);
        wr(8'h24, 8'h70);
        pulse_load();
        chk("ratio", 16'(div_ratio_out), 16'h0004);
        $display("mode test done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clock_in);
        rst_in = 0;
        t_reset();
        t_access();
        t_modes();
        end_of_test();
    end
endmodule // sol_regs_test
